// ===== src/vga_aux_control_regs.sv
/*
  Auxiliary control register bank of the transmit VGA, reached over the
  4-wire serial port, with the converter clock divided from the serial
  clock. Assumes all pins are synchronous to clk_sys and that the serial
  clock runs well below half of clk_sys.
*/
// How it works
// - With transmit enable high and bit 7 of 0x11A set, amplifier 2 follows bit 0 of 0x11A.
// - Bit 7 of 0x11A makes the register enable replace the fused one.
// - Bias trim register holds trim, select and fuse bypass bits.
// - Bits [1:0] of 0x11B give the linearity trim mode 0 to 3.
// - Bits [6:4] of monitor select choose third mux input, reset 2.
// - Bit 3 routes temperature voltage or attenuator control to converter.
// - Bits [2:0] choose the monitor output source.
// - Bit 5 of converter control enables the converter clock divider.
// - Converter clock comes from the serial clock when bit 4 is 0.
// - Bits [2:0] divide the serial clock by 2, 1, 2 or 4.
// - End of conversion is read-only bit 0 at 0x128, reset 0.
// - The 8-bit temperature result reads at 0x129.
// - The active 12-bit attenuator setting reads at 0x146 and 0x147.
// - The active step attenuator setting reads in [5:0] at 0x148.
// - With transmit enable low, a separate enable set governs amplifier 2.
// - Attenuator readback comes from the 12-bit variable_attenuator_setting input; writes to it are ignored.
`default_nettype none
module vga_aux_control_regs #(
  parameter int RESULT_W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic transmit_enable_pin,
  input wire logic amp2_on_tx_low,
  input wire logic fuse_amp2_on,
  input wire logic [3:0] fuse_amp2_bias_trim,
  input wire logic res_valid,
  input wire logic [RESULT_W-1:0] res_data,
  input wire logic [11:0] variable_attenuator_setting,
  input wire logic [5:0] step_attenuator_setting,
  output logic second_amp_on,
  output logic [3:0] second_amp_bias_trim,
  output logic second_amp_bias_trim_select,
  output logic [1:0] second_amp_linearity_trim,
  output logic [2:0] monitor_third_selector,
  output logic converter_input_selector,
  output logic [2:0] monitor_output_selector,
  output logic [3:0] external_monitor_field,
  output logic readback_level_select,
  output logic converter_clock,
  output logic converter_clock_on
);
  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  generate
    if (RESULT_W != 8) begin : g_bad_width
      $error("Result width must be 8");
    end
  endgenerate

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    vga_pkg::vga_phase_e phase;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [8:0] addr;
    logic rd_op;
    logic [7:0] rd_sh;
    logic sclk_q;
    logic sdo;
    logic sdo_oe;
    logic [7:0] bias;
    logic [7:0] en;
    logic [7:0] lin;
    logic [7:0] mon;
    logic [7:0] rbk;
    logic [7:0] conv;
    logic done;
    logic [7:0] res;
    logic [11:0] variable_attenuator;
    logic [5:0] step;
    logic div_cnt;
    logic cclk;
    logic amp_on;
    logic [3:0] trim;
  } vga_state_s;

  vga_state_s st_ff;
  vga_state_s nxt_st;
  logic rise;
  logic fall;
  logic [8:0] a;
  logic [7:0] wd;
  logic rd_clr;

  // Read multiplexer; unmapped addresses read as zero
  function automatic logic [7:0] rd_mux(input vga_state_s s,
                                        input logic [8:0] ad);
    unique case (ad)
      vga_pkg::OFS_BIAS: rd_mux = s.bias;
      vga_pkg::OFS_EN: rd_mux = s.en;
      vga_pkg::OFS_LIN: rd_mux = s.lin;
      vga_pkg::OFS_MON: rd_mux = s.mon;
      vga_pkg::OFS_RBK: rd_mux = s.rbk;
      vga_pkg::OFS_CONV: rd_mux = s.conv;
      vga_pkg::OFS_DONE: rd_mux = {7'h00, s.done};
      vga_pkg::OFS_RES: rd_mux = s.res;
      vga_pkg::OFS_VVA_LO: rd_mux = s.variable_attenuator[7:0];
      vga_pkg::OFS_VVA_HI: rd_mux = {4'h0, s.variable_attenuator[11:8]};
      vga_pkg::OFS_STEP: rd_mux = {2'h0, s.step};
      default: rd_mux = vga_pkg::RST_ZERO;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    rise = sclk & ~st_ff.sclk_q;
    fall = ~sclk & st_ff.sclk_q;
    a = {st_ff.sh[7:0], sdi};
    wd = {st_ff.sh[6:0], sdi};
    nxt_st.sclk_q = sclk;
    // Serial frame: instruction, then one data byte; extra bits ignored
    if (cs_n) begin
      nxt_st.phase = vga_pkg::VGA_IDLE;
      nxt_st.cnt = 5'h00;
      nxt_st.sdo_oe = 1'b0;
      nxt_st.sdo = 1'b0;
    end else begin
      if (st_ff.phase == vga_pkg::VGA_IDLE) begin
        nxt_st.phase = vga_pkg::VGA_INSTR;
      end
      if (rise && st_ff.phase != vga_pkg::VGA_TAIL) begin
        nxt_st.sh = {st_ff.sh[14:0], sdi};
        nxt_st.cnt = st_ff.cnt + 5'h01;
        if (st_ff.cnt == vga_pkg::CNT_INSTR_LAST) begin
          nxt_st.phase = vga_pkg::VGA_DATA;
          nxt_st.rd_op = st_ff.sh[14];
          nxt_st.addr = a;
          nxt_st.rd_sh = rd_mux(st_ff, a);
        end
        if (st_ff.cnt == vga_pkg::CNT_DATA_LAST) begin
          nxt_st.phase = vga_pkg::VGA_TAIL;
          // unused codes
          // Writes land masked; read-only bits keep their value
          if (!st_ff.rd_op) begin
            unique case (st_ff.addr)
              vga_pkg::OFS_BIAS: nxt_st.bias = wd & vga_pkg::MSK_BIAS;
              vga_pkg::OFS_EN: nxt_st.en = wd & vga_pkg::MSK_EN;
              vga_pkg::OFS_LIN: nxt_st.lin = wd & vga_pkg::MSK_ALL;
              vga_pkg::OFS_MON: nxt_st.mon = wd & vga_pkg::MSK_ALL;
              vga_pkg::OFS_RBK: nxt_st.rbk = wd & vga_pkg::MSK_RBK;
              vga_pkg::OFS_CONV: nxt_st.conv = wd & vga_pkg::MSK_CONV;
              default: nxt_st.conv = st_ff.conv;
            endcase
          end
        end
      end
      // Read data leaves on falling edges so the host samples on rising
      if (fall && st_ff.phase == vga_pkg::VGA_DATA && st_ff.rd_op) begin
        nxt_st.sdo = st_ff.rd_sh[7];
        nxt_st.rd_sh = {st_ff.rd_sh[6:0], 1'b0};
        nxt_st.sdo_oe = 1'b1;
      end
    end
    // done flag
    // Reading the result clears the flag; a new result in that cycle wins
    rd_clr = !cs_n && rise && st_ff.cnt == vga_pkg::CNT_INSTR_LAST &&
             st_ff.sh[14] && a == vga_pkg::OFS_RES;
    if (rd_clr) begin
      nxt_st.done = 1'b0;
    end
    if (res_valid && !nxt_st.done) begin
      nxt_st.done = 1'b1;
      nxt_st.res = res_data;
    end
    nxt_st.variable_attenuator = variable_attenuator_setting;
    nxt_st.step = step_attenuator_setting;
    // serial clock source
    // The unused source code stops the clock rather than guess a source
    if (!st_ff.conv[vga_pkg::BIT_DIVEN] || st_ff.conv[vga_pkg::BIT_SRC]) begin
      nxt_st.cclk = 1'b0;
      nxt_st.div_cnt = 1'b0;
    end else if (st_ff.conv[2:0] == vga_pkg::CLKR_FULL) begin
      nxt_st.cclk = sclk;
    end else if (rise) begin
      if (st_ff.conv[2:0] == vga_pkg::CLKR_QUARTER) begin
        nxt_st.div_cnt = ~st_ff.div_cnt;
        nxt_st.cclk = st_ff.cclk ^ st_ff.div_cnt;
      end else begin
        nxt_st.cclk = ~st_ff.cclk;
      end
    end
    if (!transmit_enable_pin) begin
      nxt_st.amp_on = amp2_on_tx_low;
    end else if (st_ff.en[vga_pkg::BIT_OVR]) begin
      nxt_st.amp_on = st_ff.en[vga_pkg::BIT_AMP_ON];
    end else begin
      nxt_st.amp_on = fuse_amp2_on;
    end
    nxt_st.trim = st_ff.bias[vga_pkg::BIT_OVR] ? st_ff.bias[3:0]
                                               : fuse_amp2_bias_trim;
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.phase <= vga_pkg::VGA_IDLE;
      st_ff.sclk_q <= 1'b0;
      st_ff.mon <= vga_pkg::RST_MON;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------
  // Outputs, all straight from state flops
  // --------------------------------------------------------------------
  assign sdo = st_ff.sdo;
  assign sdo_oe = st_ff.sdo_oe;
  assign second_amp_on = st_ff.amp_on;
  assign second_amp_bias_trim = st_ff.trim;
  assign second_amp_bias_trim_select = st_ff.bias[vga_pkg::BIT_TSEL];
  assign second_amp_linearity_trim = st_ff.lin[1:0];
  assign monitor_third_selector = st_ff.mon[6:4];
  assign converter_input_selector = st_ff.mon[vga_pkg::BIT_CVSEL];
  assign monitor_output_selector = st_ff.mon[2:0];
  assign external_monitor_field = st_ff.rbk[3:0];
  assign readback_level_select = st_ff.rbk[vga_pkg::BIT_LVL];
  assign converter_clock = st_ff.cclk;
  assign converter_clock_on = st_ff.conv[vga_pkg::BIT_DIVEN];

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_rise;
    sclk && !st_ff.sclk_q;
  endsequence

  sequence s_div2_on;
    st_ff.conv[5:4] == 2'b10 && st_ff.conv[2:0] == 3'h2;
  endsequence

  a_amp_tx_high: assert property (
    transmit_enable_pin && st_ff.en[7] |=>
      second_amp_on == $past(st_ff.en[0]))
    else $error("Amplifier 2 ignores its enable");

  a_amp_fuse_used: assert property (
    transmit_enable_pin && !st_ff.en[7] |=>
      second_amp_on == $past(fuse_amp2_on))
    else $error("Amplifier 2 fuse value not used");

  a_bias_trim_pick: assert property (
    st_ff.bias[7] ##1 st_ff.bias[7] |->
      second_amp_bias_trim == $past(st_ff.bias[3:0]))
    else $error("Bias trim override lost");

  a_mon_reset: assert property (
    $past(!nrst) |-> monitor_third_selector == 3'h2 &&
      monitor_output_selector == 3'h0)
    else $error("Monitor select reset wrong");

  a_div_off: assert property (
    !st_ff.conv[5] |=> !converter_clock)
    else $error("Converter clock runs while disabled");

  a_div_two_toggle: assert property (
    s_div2_on and s_rise |=> converter_clock != $past(converter_clock))
    else $error("Divide by two missed an edge");

  // A read that clears the flag may take a new result in the same cycle
  a_done_holds_res: assert property (
    st_ff.done && !rd_clr |=> $stable(st_ff.res))
    else $error("Result changed while done");

  a_eoc_set: assert property (
    res_valid && !st_ff.done |=>
      st_ff.done && st_ff.res == $past(res_data))
    else $error("Result not captured");

  a_vva_rdbk: assert property (
    1'b1 |=> st_ff.variable_attenuator == $past(variable_attenuator_setting))
    else $error("Attenuator readback stale");

  a_done_read_clr: assert property (
    rd_clr && !res_valid |=> !st_ff.done)
    else $error("Done flag not cleared by a result read");

  a_amp_tx_low: assert property (
    !transmit_enable_pin |=> second_amp_on == $past(amp2_on_tx_low))
    else $error("Amplifier 2 ignores the transmit-low set");

  a_div_full_follow: assert property (
    st_ff.conv[5:4] == 2'b10 && st_ff.conv[2:0] == vga_pkg::CLKR_FULL |=>
      converter_clock == $past(sclk))
    else $error("Undivided converter clock lost the serial clock");

  // A gated clock may only move on a serial clock rise
  a_div_gated_hold: assert property (
    st_ff.conv[5:4] == 2'b10 && st_ff.conv[2:0] != vga_pkg::CLKR_FULL &&
      !rise |=> $stable(converter_clock))
    else $error("Divided converter clock moved without a serial rise");

  a_step_rdbk: assert property (
    1'b1 |=> st_ff.step == $past(step_attenuator_setting))
    else $error("Step attenuator readback stale");
endmodule
`default_nettype wire

// ===== src/vga_pkg.sv
/*
  Constants for the auxiliary control register bank of the transmit VGA:
  register offsets, field positions, reset values and serial frame sizes.
  Assumes a 9-bit register address taken from the serial instruction word.
*/
`default_nettype none
package vga_pkg;
  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [8:0] OFS_BIAS = 9'h0_119;
  localparam logic [8:0] OFS_EN = 9'h0_11A;
  localparam logic [8:0] OFS_LIN = 9'h0_11B;
  localparam logic [8:0] OFS_MON = 9'h0_120;
  localparam logic [8:0] OFS_RBK = 9'h0_121;
  localparam logic [8:0] OFS_CONV = 9'h0_127;
  localparam logic [8:0] OFS_DONE = 9'h0_128;
  localparam logic [8:0] OFS_RES = 9'h0_129;
  localparam logic [8:0] OFS_VVA_LO = 9'h0_146;
  localparam logic [8:0] OFS_VVA_HI = 9'h0_147;
  localparam logic [8:0] OFS_STEP = 9'h0_148;
  // --------------------------------------------------------------------
  // Reset values and writable-bit masks
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MON = 8'h20;
  localparam logic [7:0] MSK_BIAS = 8'h9F;
  localparam logic [7:0] MSK_EN = 8'h81;
  localparam logic [7:0] MSK_ALL = 8'hFF;
  localparam logic [7:0] MSK_RBK = 8'h1F;
  localparam logic [7:0] MSK_CONV = 8'h37;
  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int BIT_OVR = 7;
  localparam int BIT_AMP_ON = 0;
  localparam int BIT_TSEL = 4;
  localparam int BIT_CVSEL = 3;
  localparam int BIT_LVL = 4;
  localparam int BIT_DIVEN = 5;
  localparam int BIT_SRC = 4;
  // --------------------------------------------------------------------
  // Converter clock ratio codes
  // --------------------------------------------------------------------
  localparam logic [2:0] CLKR_FULL = 3'h1;
  localparam logic [2:0] CLKR_QUARTER = 3'h3;
  // --------------------------------------------------------------------
  // Serial frame: 16-bit instruction then 8 data bits
  // --------------------------------------------------------------------
  localparam logic [4:0] CNT_INSTR_LAST = 5'h0F;
  localparam logic [4:0] CNT_DATA_LAST = 5'h17;
  typedef enum logic [1:0] {
    VGA_IDLE = 2'b00,
    VGA_INSTR = 2'b01,
    VGA_DATA = 2'b11,
    VGA_TAIL = 2'b10
  } vga_phase_e;
endpackage
`default_nettype wire

// ===== tb/vga_host_model.sv
/*
  Host controller model for the serial port of the auxiliary register bank.
  Assumes clk_sys is the bench clock; all pins change on its falling edge.
*/
`default_nettype none
module vga_host_model (
  input wire logic clk_sys,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Serial frame
  // ------------------------------------------------------------------
  // Idle pins at time zero; the serial clock rests low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // host frame programming
  // Half period of 4 clk_sys keeps well above the 2-cycle minimum
  task automatic xfer(input logic rd, input logic [8:0] ad,
                      input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] w;
    w = {rd, 6'h00, ad, wd};
    q = 8'h00;
    @(negedge clk_sys);
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // Read data phase: sdi toggles so nothing leans on a stale level
      if (rd && i < 8) sdi = ~sdi;
      else sdi = w[i];
      repeat (4) @(negedge clk_sys);
      // Undriven readback shows as unknown and cannot pass a compare
      if (i < 8) q[i] = sdo_oe ? sdo : 1'bx;
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      sclk = 1'b0;
    end
    repeat (2) @(negedge clk_sys);
    cs_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench for the auxiliary register bank of the transmit VGA.
  Assumes the host model drives the serial pins; the bench drives the rest.
*/
`default_nettype none
`define CHK(nm, ex, got) begin \
  checks++; \
  if ((got) !== (ex)) begin \
    bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, nrst = 1'b0, tx = 1'b0, low_on = 1'b0;
  logic fuse_on = 1'b0, res_valid = 1'b0;
  logic [3:0] fuse_trim = 4'h6;
  logic [7:0] res_data = 8'h00;
  logic [11:0] variable_attenuator = 12'h000;
  logic [5:0] step = 6'h00;
  logic sclk, cs_n, sdi, sdo, sdo_oe, amp_on, trim_sel, cvsel, lvl;
  logic conv_clk, conv_on;
  logic [3:0] trim, ext;
  logic [1:0] lin;
  logic [2:0] third, mon_out;
  int bad_count = 0, checks = 0, cyc = 0, edges = 0;
  // ------------------------------------------------------------------
  // Clock, instances, watchdog
  // ------------------------------------------------------------------
  always #4 clk_sys = ~clk_sys;
  always @(posedge conv_clk) edges++;
  vga_aux_control_regs vga_aux_control_regs_inst (.clk_sys(clk_sys),
    .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .transmit_enable_pin(tx), .amp2_on_tx_low(low_on),
    .fuse_amp2_on(fuse_on), .fuse_amp2_bias_trim(fuse_trim),
    .res_valid(res_valid), .res_data(res_data),
    .variable_attenuator_setting(variable_attenuator), .step_attenuator_setting(step),
    .second_amp_on(amp_on), .second_amp_bias_trim(trim),
    .second_amp_bias_trim_select(trim_sel),
    .second_amp_linearity_trim(lin), .monitor_third_selector(third),
    .converter_input_selector(cvsel), .monitor_output_selector(mon_out),
    .external_monitor_field(ext), .readback_level_select(lvl),
    .converter_clock(conv_clk), .converter_clock_on(conv_on));
  vga_host_model vga_host_model_inst (.clk_sys(clk_sys), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  // Ceiling sits at about three and a half times the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [8:0] ad, input logic [7:0] d);
    logic [7:0] q;
    vga_host_model_inst.xfer(1'b0, ad, d, q);
  endtask
  task automatic rd(input logic [8:0] ad, output logic [7:0] q);
    vga_host_model_inst.xfer(1'b1, ad, 8'h00, q);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_amp();
    logic [7:0] q;
    tx = 1'b1;
    fuse_on = 1'b1;
    wr(vga_pkg::OFS_EN, 8'hFE);
    `CHK("amp on override", 1'b0, amp_on)
    rd(vga_pkg::OFS_EN, q);
    `CHK("enable reg", 8'h80, q)
    wr(vga_pkg::OFS_EN, 8'h81);
    `CHK("amp on high", 1'b1, amp_on)
    fuse_on = 1'b0;
    wr(vga_pkg::OFS_EN, 8'h01);
    `CHK("amp on fuse", 1'b0, amp_on)
    tx = 1'b0;
    low_on = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK("amp on low set", 1'b1, amp_on)
    wr(vga_pkg::OFS_BIAS, 8'hF5);
    `CHK("bias trim", 4'h5, trim)
    `CHK("trim select", 1'b1, trim_sel)
    rd(vga_pkg::OFS_BIAS, q);
    `CHK("bias reg", 8'h95, q)
    wr(vga_pkg::OFS_BIAS, 8'h0A);
    `CHK("bias fuse trim", 4'h6, trim)
  endtask
  task automatic t_fields();
    logic [7:0] q;
    for (int c = 0; c < 4; c++) begin
      wr(vga_pkg::OFS_LIN, 8'hA8 | 8'(c));
      `CHK("lin trim", 2'(c), lin)
    end
    wr(vga_pkg::OFS_MON, 8'h4D);
    `CHK("third sel", 3'h4, third)
    `CHK("conv in sel", 1'b1, cvsel)
    `CHK("mon out", 3'h5, mon_out)
    wr(vga_pkg::OFS_MON, 8'h12);
    `CHK("conv in sel", 1'b0, cvsel)
    `CHK("mon out", 3'h2, mon_out)
    wr(vga_pkg::OFS_RBK, 8'hFF);
    rd(vga_pkg::OFS_RBK, q);
    `CHK("rbk reg", 8'h1F, q)
    `CHK("level sel", 1'b1, lvl)
    `CHK("ext field", 4'hF, ext)
    wr(vga_pkg::OFS_RBK, 8'h05);
    `CHK("level sel", 1'b0, lvl)
    `CHK("ext field", 4'h5, ext)
  endtask
  // Edge counts are taken over one full 24-rise read frame
  task automatic t_clk();
    logic [7:0] ctl [6] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h31, 8'h01};
    int exp_e [6] = '{12, 24, 12, 6, 0, 0};
    logic [7:0] q;
    for (int k = 0; k < 6; k++) begin
      wr(vga_pkg::OFS_CONV, ctl[k]);
      `CHK("clock on", ctl[k][5], conv_on)
      edges = 0;
      rd(vga_pkg::OFS_CONV, q);
      `CHK("conv reg", ctl[k] & 8'h37, q)
      `CHK("conv edges", exp_e[k], edges)
    end
  endtask
  task automatic pulse(input logic [7:0] d);
    @(negedge clk_sys);
    res_data = d;
    res_valid = 1'b1;
    @(negedge clk_sys);
    res_valid = 1'b0;
    res_data = ~d;
  endtask
  task automatic t_conv();
    logic [7:0] q;
    pulse(8'hA5);
    pulse(8'h3C);
    rd(vga_pkg::OFS_DONE, q);
    `CHK("done set", 8'h01, q)
    rd(vga_pkg::OFS_RES, q);
    `CHK("result", 8'hA5, q)
    rd(vga_pkg::OFS_DONE, q);
    `CHK("done cleared", 8'h00, q)
    pulse(8'h5E);
    wr(vga_pkg::OFS_RES, 8'h00);
    rd(vga_pkg::OFS_RES, q);
    `CHK("result ro", 8'h5E, q)
  endtask
  task automatic t_rdbk();
    logic [7:0] q;
    variable_attenuator = 12'hABC;
    step = 6'h2A;
    wr(vga_pkg::OFS_VVA_LO, 8'h00);
    rd(vga_pkg::OFS_VVA_LO, q);
    `CHK("vva low", 8'hBC, q)
    rd(vga_pkg::OFS_VVA_HI, q);
    `CHK("vva high", 8'h0A, q)
    rd(vga_pkg::OFS_STEP, q);
    `CHK("step", 8'h2A, q)
    rd(9'h1FF, q);
    `CHK("unmapped", 8'h00, q)
  endtask
  // Mid-run reset with written registers must restore the monitor, enable and readback reset values
  task automatic t_reset();
    logic [7:0] q;
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    rd(vga_pkg::OFS_MON, q);
    `CHK("mon after reset", 8'h20, q)
    `CHK("third after reset", 3'h2, third)
    rd(vga_pkg::OFS_EN, q);
    `CHK("enable after reset", 8'h00, q)
    `CHK("ext after reset", 4'h0, ext)
    `CHK("level after reset", 1'b0, lvl)
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [7:0] q;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    rd(vga_pkg::OFS_MON, q);
    `CHK("mon reset", 8'h20, q)
    `CHK("third reset", 3'h2, third)
    rd(vga_pkg::OFS_DONE, q);
    `CHK("done reset", 8'h00, q)
    t_amp();
    t_fields();
    t_clk();
    t_conv();
    t_rdbk();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
